// File: inc/pgf_pkg.sv
package pgf_pkg;

	localparam int unsigned NUM_PINS       = 5;
	localparam int unsigned NUM_REGS       = 7;
	localparam int unsigned CNT_W          = 24;
	localparam int unsigned CFG_W          = 12;

	// clock and timing
	localparam int unsigned CLK_FREQ_KHZ   = 100000;
	localparam int unsigned DEB_STEP_MS    = 1;
	localparam int unsigned DEB_STEP_CYCLES = DEB_STEP_MS * CLK_FREQ_KHZ;
	localparam int unsigned FAULT_TIME_MS  = 100;
	localparam int unsigned FAULT_CYCLES   = FAULT_TIME_MS * CLK_FREQ_KHZ;

	// register byte offsets; pin configuration i sits at ADDR_CFG0 + 4*i
	localparam logic [7:0] ADDR_CFG0       = 8'h00;
	localparam logic [7:0] ADDR_DEBOUNCE   = 8'h14;
	localparam logic [7:0] ADDR_REG_CTRL   = 8'h18;
	localparam logic [7:0] ADDR_REG_SEL    = 8'h1C;
	localparam logic [7:0] ADDR_STATUS     = 8'h20;

	// pin configuration fields
	localparam int unsigned CFG_FUNC_LSB   = 0;
	localparam int unsigned CFG_LEVEL_BIT  = 2;
	localparam int unsigned CFG_POL_BIT    = 3;
	localparam int unsigned CFG_SENSE_BIT  = 4;
	localparam int unsigned CFG_WEN_BIT    = 5;
	localparam int unsigned CFG_PULL_BIT   = 6;
	localparam int unsigned CFG_SRC_LSB    = 8;
	localparam int unsigned CFG_FWD_LSB    = 10;
	localparam logic [11:0] CFG_RESET      = 12'h001;

	// pin functions
	localparam logic [1:0] FUNC_ALT        = 2'h0;
	localparam logic [1:0] FUNC_INPUT      = 2'h1;
	localparam logic [1:0] FUNC_OPEN_DRAIN = 2'h2;
	localparam logic [1:0] FUNC_PUSH_PULL  = 2'h3;

	// output sources
	localparam logic [1:0] SRC_LEVEL       = 2'h0;
	localparam logic [1:0] SRC_FORWARD     = 2'h1;
	localparam logic [1:0] SRC_SEQUENCER   = 2'h2;
	localparam logic [1:0] SRC_FAULT       = 2'h3;

	// regulator registers
	localparam int unsigned CTRL_VSEL_LSB  = 8;
	localparam int unsigned SEL_ON_LSB     = 0;
	localparam int unsigned SEL_VSEL_LSB   = 16;

	// status fields
	localparam int unsigned ST_LEVEL_LSB   = 0;
	localparam int unsigned ST_EVENT_LSB   = 8;
	localparam int unsigned ST_SYSREQ_BIT  = 16;
	localparam int unsigned ST_PWRREQ_BIT  = 17;
	localparam int unsigned ST_FAULT_BIT   = 18;
	localparam int unsigned ST_OPER_BIT    = 19;

endpackage : pgf_pkg

// File: inc/pgf_deb_if.sv
`timescale 1ns/1ps
interface pgf_deb_if;
	logic [4:0]  raw;
	logic [4:0]  enable;
	logic [23:0] limit;
	logic [4:0]  level;

	modport ctrl (output raw, output enable, output limit, input level);
	modport filt (input raw, input enable, input limit, output level);
endinterface : pgf_deb_if

// File: logic/pgf_debounce.sv
`timescale 1ns/1ps
module pgf_debounce (
	input wire logic hclk,
	input wire logic hresetn,
	pgf_deb_if.filt  dif
);
	typedef struct packed {
		logic [4:0]       level;
		logic [4:0][23:0] cnt;
	} pgf_deb_state_type;

	pgf_deb_state_type q;
	pgf_deb_state_type d;

	always_comb
	begin
		d = q;
		for (int i = 0; i < pgf_pkg::NUM_PINS; i++)
		begin
			if (!dif.enable[i])
			begin
				d.level[i] = dif.raw[i];
				d.cnt[i]   = 24'h00_0000;
			end
			else if (dif.raw[i] == q.level[i])
				d.cnt[i] = 24'h00_0000;
			else if (({1'b0, q.cnt[i]} + 25'h000_0001) >= {1'b0, dif.limit})
			begin
				// new level has held for the whole programmed time
				d.level[i] = dif.raw[i];
				d.cnt[i]   = 24'h00_0000;
			end
			else
				d.cnt[i] = q.cnt[i] + 24'h00_0001;
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			q <= '0;
		else
			q <= d;
	end

	assign dif.level = q.level;

endmodule : pgf_debounce

// File: logic/pgf_gpio_top.sv
`timescale 1ns/1ps
module pgf_gpio_top #(
	parameter logic [23:0] DEB_STEP_CYCLES = 24'(pgf_pkg::DEB_STEP_CYCLES),
	parameter logic [23:0] FAULT_CYCLES    = 24'(pgf_pkg::FAULT_CYCLES)
) (
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output wire logic        hreadyout,
	output wire logic [31:0] hrdata,
	output wire logic        hresp,
	input  wire logic [4:0]  pin_in,
	output wire logic [4:0]  pin_out,
	output wire logic [4:0]  pin_oe,
	output wire logic [4:0]  pull_up_en,
	output wire logic [4:0]  pull_down_en,
	input  wire logic        gpio_operational,
	input  wire logic        supply_low,
	input  wire logic [4:0]  seq_pin_level,
	input  wire logic [6:0]  seq_on_we,
	input  wire logic [6:0]  seq_on_val,
	input  wire logic [6:0]  seq_vsel_we,
	input  wire logic [6:0]  seq_vsel_val,
	output wire logic [6:0]  reg_on,
	output wire logic [6:0]  reg_vsel,
	output wire logic [4:0]  input_event_flag,
	output wire logic        wakeup_req,
	output wire logic        wait_step_edge,
	output wire logic        system_request_bit,
	output wire logic        power_request_bit,
	output wire logic        power_down_start,
	output wire logic        watchdog_refresh,
	output wire logic        watchdog_hold,
	output wire logic        supply_fault_n
);
	typedef struct packed {
		logic [4:0]        sync1;
		logic [4:0]        sync2;
		logic              low_sync1;
		logic              low_sync2;
		logic [4:0][11:0]  cfg;
		logic [3:0]        deb_sel;
		logic [13:0]       on_sel;
		logic [13:0]       vsel_sel;
		logic [6:0]        reg_on;
		logic [6:0]        reg_vsel;
		logic [4:0]        act_prev;
		logic [4:0]        events;
		logic [23:0]       fault_cnt;
		logic              fault_n;
		logic              sys_req;
		logic              pwr_req;
		logic              pd_start;
		logic              wdg_refresh;
		logic              wdg_hold;
		logic              wakeup;
		logic              wait_edge;
		logic [4:0]        pin_out;
		logic [4:0]        pin_oe;
		logic [4:0]        pull_up;
		logic [4:0]        pull_down;
		logic              hreadyout;
		logic [31:0]       hrdata;
		logic              wr_pend;
		logic              rd_pend;
		logic [7:0]        addr;
	} pgf_state_type;

	pgf_state_type q;
	pgf_state_type d;

	pgf_deb_if dif ();

	pgf_debounce u_debounce (
		.hclk    (hclk),
		.hresetn (hresetn),
		.dif     (dif.filt)
	);

	// edge of the pin named by a 2-bit select; code 0 means no pin
	function automatic logic sel_edge(input logic [1:0] sel, input logic [4:0] edges);
		return (sel != 2'h0) ? edges[sel] : 1'b0;
	endfunction : sel_edge

	assign dif.raw    = q.sync2;
	assign dif.limit  = 24'(q.deb_sel * DEB_STEP_CYCLES);

	always_comb
	begin
		logic [4:0]  func_in;
		logic [4:0]  func_alt;
		logic [4:0]  act;
		logic [4:0]  rise;
		logic [4:0]  fall;
		logic [4:0]  deb_en;
		logic [4:0]  in_rise;
		logic [4:0]  in_fall;
		logic [4:0]  ev_clr;
		logic [4:0]  ev_new;
		logic        wk;
		logic [1:0]  func;
		logic [1:0]  src;
		logic        lvl;
		logic        take;
		logic [31:0] rd;
		func_in  = 5'h00;
		func_alt = 5'h00;
		act      = 5'h00;
		deb_en   = 5'h00;
		ev_clr   = 5'h00;
		wk       = 1'b0;
		func     = 2'h0;
		src      = 2'h0;
		lvl      = 1'b0;
		rise     = 5'h00;
		fall     = 5'h00;
		in_rise  = 5'h00;
		in_fall  = 5'h00;
		ev_new   = 5'h00;
		take     = 1'b0;
		rd       = 32'h0000_0000;
		d        = q;

		// pin and supply comparator synchronisers
		d.sync1     = pin_in;
		d.sync2     = q.sync1;
		d.low_sync1 = supply_low;
		d.low_sync2 = q.low_sync1;

		for (int i = 0; i < pgf_pkg::NUM_PINS; i++)
		begin
			func        = q.cfg[i][pgf_pkg::CFG_FUNC_LSB +: 2];
			func_in[i]  = (func == pgf_pkg::FUNC_INPUT);
			func_alt[i] = (func == pgf_pkg::FUNC_ALT) && (i == 0 || i == 2 || i == 4);
			// debounce on inputs and on alternate inputs alike
			deb_en[i]   = (func_in[i] | func_alt[i]) & q.cfg[i][pgf_pkg::CFG_LEVEL_BIT];
			// active level follows the polarity bit
			act[i]      = dif.level[i] ~^ q.cfg[i][pgf_pkg::CFG_POL_BIT];
		end
		dif.enable = deb_en;

		// no transitions seen outside the operating modes
		rise       = act & ~q.act_prev & {5{gpio_operational}};
		fall       = ~act & q.act_prev & {5{gpio_operational}};
		d.act_prev = act;
		in_rise    = rise & func_in;
		in_fall    = fall & func_in;

		// software register writes, one cycle after the address phase
		if (q.wr_pend)
		begin
			if (q.addr[7:2] < 6'(pgf_pkg::NUM_PINS))
				d.cfg[q.addr[4:2]] = hwdata[11:0];
			unique case (q.addr)
				pgf_pkg::ADDR_DEBOUNCE:
					d.deb_sel = hwdata[3:0];
				pgf_pkg::ADDR_REG_CTRL:
				begin
					// writes land even on input-owned bits
					d.reg_on   = hwdata[6:0];
					d.reg_vsel = hwdata[pgf_pkg::CTRL_VSEL_LSB +: 7];
				end
				pgf_pkg::ADDR_REG_SEL:
				begin
					d.on_sel   = hwdata[pgf_pkg::SEL_ON_LSB +: 14];
					d.vsel_sel = hwdata[pgf_pkg::SEL_VSEL_LSB +: 14];
				end
				pgf_pkg::ADDR_STATUS:
					ev_clr = hwdata[pgf_pkg::ST_EVENT_LSB +: 5];
				default:
					ev_clr = 5'h00;
			endcase
		end

		// input events; pin four as system request also raises one
		ev_new      = in_rise;
		ev_new[4]   = in_rise[4] | (func_alt[4] & rise[4]);
		d.events    = (q.events & ~ev_clr) | ev_new;

		// wakeup generation
		for (int i = 0; i < pgf_pkg::NUM_PINS; i++)
		begin
			if (func_in[i] && q.cfg[i][pgf_pkg::CFG_WEN_BIT])
			begin
				if (q.cfg[i][pgf_pkg::CFG_SENSE_BIT])
					wk = wk | (act[i] & gpio_operational);
				else
					wk = wk | rise[i];
			end
		end
		wk = wk | (func_alt[4] & rise[4]);
		wk = wk | (func_alt[2] & rise[2] & q.cfg[2][pgf_pkg::CFG_WEN_BIT]);
		d.wakeup = wk;

		// system request on pin four; release starts power-down, no event
		if (func_alt[4] && gpio_operational)
			d.sys_req = act[4];
		d.pd_start = func_alt[4] & fall[4];

		// power request on pin two
		if (func_alt[2] && gpio_operational)
			d.pwr_req = act[2];

		// watchdog refresh and hold on pin zero
		d.wdg_refresh = func_alt[0] & rise[0];
		d.wdg_hold    = func_alt[0] & act[0] & gpio_operational;

		// sequencer hold step on pin three
		d.wait_edge = in_rise[3];

		// regulator control from pins one to three
		for (int r = 0; r < pgf_pkg::NUM_REGS; r++)
		begin
			if (seq_on_we[r] && q.on_sel[2*r +: 2] == 2'h0)
				d.reg_on[r] = seq_on_val[r];
			if (seq_vsel_we[r] && q.vsel_sel[2*r +: 2] == 2'h0)
				d.reg_vsel[r] = seq_vsel_val[r];
			if (sel_edge(q.on_sel[2*r +: 2], in_rise))
				d.reg_on[r] = 1'b1;
			if (sel_edge(q.on_sel[2*r +: 2], in_fall))
				d.reg_on[r] = 1'b0;
			if (sel_edge(q.vsel_sel[2*r +: 2], in_rise))
				d.reg_vsel[r] = 1'b1;
			if (sel_edge(q.vsel_sel[2*r +: 2], in_fall))
				d.reg_vsel[r] = 1'b0;
		end

		// supply low must persist beyond the fault time
		if (q.low_sync2)
		begin
			if (q.fault_cnt < FAULT_CYCLES)
				d.fault_cnt = q.fault_cnt + 24'h00_0001;
			else
				d.fault_n = 1'b0;
		end
		else
		begin
			d.fault_cnt = 24'h00_0000;
			d.fault_n   = 1'b1;
		end

		// output drivers
		for (int i = 0; i < pgf_pkg::NUM_PINS; i++)
		begin
			func = q.cfg[i][pgf_pkg::CFG_FUNC_LSB +: 2];
			src  = q.cfg[i][pgf_pkg::CFG_SRC_LSB +: 2];
			unique case (src)
				pgf_pkg::SRC_LEVEL:
					lvl = q.cfg[i][pgf_pkg::CFG_LEVEL_BIT];
				pgf_pkg::SRC_FORWARD:
					if (i == 0 || i == 1 || i == 3)
						lvl = dif.level[q.cfg[i][pgf_pkg::CFG_FWD_LSB +: 2]];
					else
						lvl = q.cfg[i][pgf_pkg::CFG_LEVEL_BIT];
				pgf_pkg::SRC_SEQUENCER:
					lvl = seq_pin_level[i];
				pgf_pkg::SRC_FAULT:
					lvl = q.fault_n ^ q.cfg[i][pgf_pkg::CFG_LEVEL_BIT];
			endcase
			d.pin_out[i]   = 1'b0;
			d.pin_oe[i]    = 1'b0;
			d.pull_up[i]   = (func == pgf_pkg::FUNC_OPEN_DRAIN) & q.cfg[i][pgf_pkg::CFG_PULL_BIT];
			d.pull_down[i] = func_in[i] & q.cfg[i][pgf_pkg::CFG_PULL_BIT];
			// drivers released while not operational
			if (func == pgf_pkg::FUNC_PUSH_PULL)
			begin
				d.pin_out[i] = lvl;
				d.pin_oe[i]  = gpio_operational;
			end
			else if (func == pgf_pkg::FUNC_OPEN_DRAIN)
				d.pin_oe[i] = gpio_operational & ~lvl;
		end

		// bus slave: writes take no wait state, reads take one
		take        = hsel & hready & htrans[1];
		d.wr_pend   = take & hwrite;
		d.rd_pend   = take & ~hwrite;
		d.hreadyout = ~(take & ~hwrite);
		if (take)
			d.addr = haddr[7:0];
		if (q.rd_pend)
		begin
			if (q.addr[7:2] < 6'(pgf_pkg::NUM_PINS) && q.addr[1:0] == 2'h0)
				rd = {20'h0_0000, q.cfg[q.addr[4:2]]};
			unique case (q.addr)
				pgf_pkg::ADDR_DEBOUNCE:
					rd = {28'h000_0000, q.deb_sel};
				pgf_pkg::ADDR_REG_CTRL:
					rd = {17'h0_0000, q.reg_vsel, 1'b0, q.reg_on};
				pgf_pkg::ADDR_REG_SEL:
					rd = {2'h0, q.vsel_sel, 2'h0, q.on_sel};
				pgf_pkg::ADDR_STATUS:
					rd = {12'h000, gpio_operational, q.fault_n, q.pwr_req, q.sys_req,
						3'h0, q.events, 3'h0, act};
				default:
					rd = rd;
			endcase
			d.hrdata = rd;
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			q           <= '0;
			q.cfg       <= {5{pgf_pkg::CFG_RESET}};
			q.fault_n   <= 1'b1;
			q.act_prev  <= {5{~pgf_pkg::CFG_RESET[pgf_pkg::CFG_POL_BIT]}}; // equals act at reset, no false edge
			q.hreadyout <= 1'b1;
		end
		else
			q <= d;
	end

	assign hreadyout          = q.hreadyout;
	assign hrdata             = q.hrdata;
	assign hresp              = 1'b0;
	assign pin_out            = q.pin_out;
	assign pin_oe             = q.pin_oe;
	assign pull_up_en         = q.pull_up;
	assign pull_down_en       = q.pull_down;
	assign reg_on             = q.reg_on;
	assign reg_vsel           = q.reg_vsel;
	assign input_event_flag   = q.events;
	assign wakeup_req         = q.wakeup;
	assign wait_step_edge     = q.wait_edge;
	assign system_request_bit = q.sys_req;
	assign power_request_bit  = q.pwr_req;
	assign power_down_start   = q.pd_start;
	assign watchdog_refresh   = q.wdg_refresh;
	assign watchdog_hold      = q.wdg_hold;
	assign supply_fault_n     = q.fault_n;

endmodule : pgf_gpio_top

// File: verif/pgf_gpio_assertions.sv
`timescale 1ns/1ps
module pgf_gpio_assertions #(
	parameter logic [23:0] FAULT_CYCLES = 24'h00_0014
) (
	input wire logic       hclk,
	input wire logic       hresetn,
	input wire logic       hsel,
	input wire logic [1:0] htrans,
	input wire logic       hwrite,
	input wire logic       hready,
	input wire logic       hreadyout,
	input wire logic [4:0] pin_out,
	input wire logic [4:0] pin_oe,
	input wire logic [4:0] pull_up_en,
	input wire logic [4:0] pull_down_en,
	input wire logic       gpio_operational,
	input wire logic       supply_low,
	input wire logic [4:0] input_event_flag,
	input wire logic       wait_step_edge,
	input wire logic       system_request_bit,
	input wire logic       power_down_start,
	input wire logic       watchdog_refresh,
	input wire logic       supply_fault_n
);
	logic [23:0] low_cnt_q;
	logic [23:0] low_cnt_d;

	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);

	// run length of the raw low-supply input
	always_comb
		low_cnt_d = supply_low ? low_cnt_q + 24'h00_0001 : 24'h00_0000;
	always_ff @(posedge hclk or negedge hresetn)
		if (!hresetn)
			low_cnt_q <= 24'h00_0000;
		else
			low_cnt_q <= low_cnt_d;

	a_read_wait: assert property (hsel && hready && htrans[1] && !hwrite |=> !hreadyout ##1 hreadyout)
		else $error("read wait state wrong");
	a_fault_late: assert property ($fell(supply_fault_n) |-> low_cnt_q > FAULT_CYCLES)
		else $error("supply fault too early");
	a_fault_due: assert property (low_cnt_q == FAULT_CYCLES + 24'h00_0008 |-> !supply_fault_n)
		else $error("supply fault missing");
	a_idle_no_drive: assert property (!gpio_operational [*2] |-> pin_oe == 5'h00)
		else $error("pin driven while idle");
	a_idle_no_event: assert property (!gpio_operational [*3] |-> (input_event_flag & ~$past(input_event_flag)) == 5'h00)
		else $error("event while idle");
	a_pull_exclusive: assert property ((pull_up_en & pull_down_en) == 5'h00)
		else $error("both pulls on");
	a_od_no_high: assert property ((pull_up_en & pin_out) == 5'h00)
		else $error("open drain drives high");
	a_refresh_pulse: assert property (watchdog_refresh |=> !watchdog_refresh)
		else $error("refresh not a pulse");
	a_pdown_pulse: assert property (power_down_start |-> !system_request_bit ##1 !power_down_start)
		else $error("power down pulse wrong");
	a_wait_pulse: assert property (wait_step_edge |=> !wait_step_edge)
		else $error("wait step not a pulse");
endmodule : pgf_gpio_assertions

bind pgf_gpio_top pgf_gpio_assertions #(.FAULT_CYCLES(FAULT_CYCLES)) u_pgf_gpio_assertions (.hclk, .hresetn, .hsel,
	.htrans, .hwrite, .hready, .hreadyout, .pin_out, .pin_oe, .pull_up_en, .pull_down_en, .gpio_operational,
	.supply_low, .input_event_flag, .wait_step_edge, .system_request_bit, .power_down_start, .watchdog_refresh,
	.supply_fault_n);

// File: verif/pgf_pin_model.sv
`timescale 1ns/1ps
module pgf_pin_model (
	input wire logic       hclk,
	input wire logic [4:0] ext_level,
	input wire logic [4:0] ext_drive,
	input wire logic [4:0] pin_out,
	input wire logic [4:0] pin_oe,
	input wire logic [4:0] pull_up_en,
	input wire logic [4:0] pull_down_en,
	output logic     [4:0] pin_level
);
	logic [4:0] last_q;

	always_ff @(posedge hclk)
		last_q <= pin_level;

	// open drain drives pin_out low, so one term serves both driver types
	always_comb
		for (int i = 0; i < 5; i++)
			if (pin_oe[i])
				pin_level[i] = pin_out[i];
			else if (ext_drive[i])
				pin_level[i] = ext_level[i];
			else if (pull_up_en[i])
				pin_level[i] = 1'b1;
			else if (pull_down_en[i])
				pin_level[i] = 1'b0;
			else
				pin_level[i] = ~last_q[i];
endmodule : pgf_pin_model

// File: verif/pgf_gpio_top_tb.sv
`timescale 1ns/1ps
`define CHK(n, e, g) \
	begin \
		samples_checked++; \
		if ((g) !== (e)) \
		begin \
			fail_count++; \
			$display("MISMATCH %s exp=%0h got=%0h", n, e, g); \
		end \
	end
module pgf_gpio_top_tb;
	typedef struct packed {
		logic [11:0] cfg;
		logic [3:0]  exp;
	} pgf_row_type;
	localparam pgf_row_type ROWS [9] = '{'{12'h007, 4'hc}, '{12'h003, 4'h8}, '{12'h002, 4'h8}, '{12'h046, 4'h2},
		'{12'h041, 4'h1}, '{12'h000, 4'h0}, '{12'h303, 4'hc}, '{12'h307, 4'h8}, '{12'h203, 4'hc}};
	localparam logic [7:0] ST = pgf_pkg::ADDR_STATUS;
	logic        hclk = 1'b0;
	logic        hresetn;
	logic        hsel;
	logic [31:0] haddr;
	logic [1:0]  htrans;
	logic        hwrite;
	logic [2:0]  hsize;
	logic [31:0] hwdata;
	logic        hreadyout;
	logic [31:0] hrdata;
	logic        hresp;
	logic [4:0]  pin_in;
	logic [4:0]  pin_out;
	logic [4:0]  pin_oe;
	logic [4:0]  pull_up_en;
	logic [4:0]  pull_down_en;
	logic        gpio_operational;
	logic        supply_low;
	logic [4:0]  seq_pin_level;
	logic [6:0]  seq_on_we;
	logic [6:0]  seq_on_val;
	logic [6:0]  seq_vsel_we;
	logic [6:0]  seq_vsel_val;
	logic [6:0]  reg_on;
	logic [6:0]  reg_vsel;
	logic [4:0]  input_event_flag;
	logic        wakeup_req;
	logic        wait_step_edge;
	logic        system_request_bit;
	logic        power_request_bit;
	logic        power_down_start;
	logic        watchdog_refresh;
	logic        watchdog_hold;
	logic        supply_fault_n;
	logic [4:0]  ext_level;
	logic [4:0]  ext_drive;
	int          fail_count = 0;
	int          samples_checked = 0;
	int          cycles = 0;
	int          wake_n = 0;
	int          pd_n = 0;
	int          wd_n = 0;
	int          ws_n = 0;

	pgf_gpio_top #(.DEB_STEP_CYCLES(24'h00_0004), .FAULT_CYCLES(24'h00_0014)) u_pgf_gpio_top (.hclk, .hresetn,
		.hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout), .hreadyout, .hrdata, .hresp,
		.pin_in, .pin_out, .pin_oe, .pull_up_en, .pull_down_en, .gpio_operational, .supply_low, .seq_pin_level,
		.seq_on_we, .seq_on_val, .seq_vsel_we, .seq_vsel_val, .reg_on, .reg_vsel, .input_event_flag, .wakeup_req,
		.wait_step_edge, .system_request_bit, .power_request_bit, .power_down_start, .watchdog_refresh,
		.watchdog_hold, .supply_fault_n);

	pgf_pin_model u_pgf_pin_model (.hclk, .ext_level, .ext_drive, .pin_out, .pin_oe, .pull_up_en, .pull_down_en,
		.pin_level(pin_in));

	always #5 hclk = ~hclk;

	// pulse counters and the hang limit
	always @(posedge hclk)
	begin
		wake_n += int'(wakeup_req);
		pd_n += int'(power_down_start);
		wd_n += int'(watchdog_refresh);
		ws_n += int'(wait_step_edge);
		cycles++;
		if (cycles == 4000)
		begin
			fail_count++;
			stop_test();
		end
	end

	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
		hsel <= 1'b1;
		haddr <= {24'h00_0000, a};
		hwrite <= w;
		htrans <= 2'h2;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		q = hrdata;
	endtask : xfer

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		xfer(1'b1, a, d, q);
	endtask : wr

	task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] q;
		xfer(1'b0, a, 32'h0000_0000, q);
		`CHK("hrdata", e, q)
		`CHK("hresp", 1'b0, hresp)
	endtask : rdchk

	task automatic wcfg(input int i, input logic [11:0] c);
		wr(8'(4 * i), {20'h0_0000, c});
	endtask : wcfg

	task automatic cyc(input int n);
		repeat (n) @(posedge hclk);
	endtask : cyc

	task automatic drv(input int i, input logic v);
		ext_level[i] <= v;
		cyc(8);
	endtask : drv

	task automatic clr();
		@(negedge hclk);
		wake_n = 0;
		pd_n = 0;
		wd_n = 0;
		ws_n = 0;
		@(posedge hclk);
	endtask : clr

	task automatic stop_test();
		$display("checks %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : stop_test

	initial
	begin
		hresetn = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0000_0000;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0000_0000;
		gpio_operational = 1'b1;
		supply_low = 1'b0;
		seq_pin_level = 5'h1f;
		seq_on_we = 7'h00;
		seq_on_val = 7'h00;
		seq_vsel_we = 7'h00;
		seq_vsel_val = 7'h00;
		ext_level = 5'h00;
		ext_drive = 5'h1f;
		repeat (8) @(posedge hclk);
		`CHK("reset", 4'hc, {hreadyout, supply_fault_n, |reg_on, |pin_oe})
		hresetn <= 1'b1;
		rdchk(pgf_pkg::ADDR_CFG0, 32'h0000_0001);
		`CHK("evt_reset", 5'h00, input_event_flag)
		wr(8'h30, 32'hffff_ffff);
		rdchk(8'h30, 32'h0000_0000);
		for (int i = 0; i < 9; i++)
		begin
			wcfg(1, ROWS[i].cfg);
			cyc(3);
			`CHK("pin1", ROWS[i].exp, {pin_oe[1], pin_out[1], pull_up_en[1], pull_down_en[1]})
		end
		// pin 1 owns converter 0 and linear 3 enables and converter 2 select
		wcfg(1, 12'h009);
		wr(pgf_pkg::ADDR_REG_SEL, 32'h0010_0041);
		wr(ST, 32'h0000_1f00);
		drv(1, 1'b1);
		`CHK("reg_on", 7'h09, reg_on)
		`CHK("reg_vsel", 7'h04, reg_vsel)
		rdchk(ST, 32'h000c_021f);
		seq_on_we <= 7'h03;
		seq_on_val <= 7'h02;
		seq_vsel_we <= 7'h04;
		cyc(1);
		seq_on_we <= 7'h00;
		seq_vsel_we <= 7'h00;
		cyc(2);
		`CHK("seq", 14'h020b, {reg_vsel, reg_on})
		wr(pgf_pkg::ADDR_REG_CTRL, 32'h0000_0408);
		cyc(1);
		`CHK("sw", 7'h08, reg_on)
		drv(1, 1'b0);
		`CHK("off", 14'h0000, {reg_vsel, reg_on})
		wcfg(2, 12'h029);
		clr();
		drv(2, 1'b1);
		`CHK("wake_edge", 1, wake_n)
		drv(2, 1'b0);
		wcfg(2, 12'h039);
		drv(2, 1'b1);
		`CHK("wake_lvl", 1'b1, wakeup_req)
		drv(2, 1'b0);
		wcfg(2, 12'h009);
		clr();
		drv(2, 1'b1);
		`CHK("wake_off", 0, wake_n)
		drv(2, 1'b0);
		// debounce of 8 cycles swallows a 5-cycle glitch
		wr(pgf_pkg::ADDR_DEBOUNCE, 32'h0000_0002);
		wcfg(3, 12'h00d);
		clr();
		ext_level[3] <= 1'b1;
		cyc(5);
		drv(3, 1'b0);
		cyc(12);
		`CHK("glitch", 0, ws_n)
		drv(3, 1'b1);
		cyc(12);
		`CHK("settled", 1, ws_n)
		drv(3, 1'b0);
		wr(pgf_pkg::ADDR_DEBOUNCE, 32'h0000_0000);
		wr(ST, 32'h0000_1f00);
		wcfg(4, 12'h008);
		wcfg(0, 12'h008);
		wcfg(2, 12'h028);
		clr();
		drv(4, 1'b1);
		`CHK("sysreq", 3'h7, {system_request_bit, input_event_flag[4], wake_n == 1})
		drv(0, 1'b1);
		drv(2, 1'b1);
		`CHK("alt", 4'hf, {power_request_bit, watchdog_hold, wd_n == 1, wake_n == 2})
		`CHK("alt_evt", 5'h10, input_event_flag)
		wr(ST, 32'h0000_1f00);
		drv(4, 1'b0);
		`CHK("sysreq_off", 3'h1, {system_request_bit, input_event_flag[4], pd_n == 1})
		wcfg(0, 12'h009);
		wcfg(1, 12'h103);
		for (int v = 0; v < 2; v++)
		begin
			drv(0, v[0]);
			`CHK("fwd", v[0], pin_out[1])
		end
		supply_low <= 1'b1;
		cyc(15);
		`CHK("fault_early", 1'b1, supply_fault_n)
		cyc(15);
		`CHK("fault", 1'b0, supply_fault_n)
		supply_low <= 1'b0;
		gpio_operational <= 1'b0;
		wr(ST, 32'h0000_1f00);
		clr();
		drv(3, 1'b1);
		`CHK("idle", 11'h000, {pin_oe, input_event_flag, ws_n == 1})
		stop_test();
	end
endmodule : pgf_gpio_top_tb
